// ---- rtl/exec_pkg.sv ----
// shared constants and types for the subtract/xor/swap execute block
package exec_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int WATCHDOG_W = 8;
  localparam int PRE_W = 8;
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [WATCHDOG_W-1:0] WATCHDOG_CLR = 8'h00;
  localparam logic [2:0] DIR_SEL_A = 3'h5;
  localparam logic [2:0] DIR_SEL_B = 3'h6;
  localparam logic [2:0] DIR_SEL_C = 3'h7;
  localparam int FLAG_C = 0;
  localparam int FLAG_DIGIT = 1;
  localparam int FLAG_Z = 2;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_SUBTRACT_FROM_LITERAL,
    OP_SUBTRACT_FROM_REGISTER,
    OP_SUBTRACT_REGISTER_WITH_BORROW,
    OP_NIBBLE_SWAP,
    OP_XOR_LITERAL,
    OP_XOR_REGISTER,
    OP_LOAD_DIRECTION
  } op_e;
endpackage

// ---- rtl/sub_unit.sv ----
// combinational 8-bit subtractor with difference, carry and digit carry outputs
`timescale 1ns/1ps
module sub_unit #(
  parameter int W = 8
) (
  input wire logic [W-1:0] minuend,
  input wire logic [W-1:0] subtrahend,
  input wire logic carry_in,
  output logic [W-1:0] diff,
  output logic carry_out,
  output logic digit_carry_out
);
  logic [W:0] full;
  logic [4:0] low;
  // a-b-!c computed as a + ~b + c; carry set means no borrow
  always_comb begin
    full = {1'b0, minuend} + {1'b0, ~subtrahend} + {{W{1'b0}}, carry_in};
    low = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
    diff = full[W-1:0];
    carry_out = full[W];
    digit_carry_out = low[4];
  end
endmodule

// ---- rtl/subtract_xor_swap_execute.sv ----
// execute datapath: subtracts, xor, nibble swap, direction load and sleep
`timescale 1ns/1ps
// Operation
// RULE1 - literal minus working into working; carry and digit carry mean no borrow
// RULE2 - register minus working; carry and digit carry mean no borrow
// RULE3 - register minus working minus inverted carry; updates carry, digit carry, zero
// RULE4 - destination bit 0 writes working, 1 writes back the file register
// RULE5 - nibble swap exchanges register halves; no flag changes
// RULE6 - working xor literal into working; only zero flag changes
// RULE7 - working xor register, routed by destination bit; only zero changes
// RULE8 - operand 5, 6, 7 loads port A, B, C direction from working
// RULE9 - sleep clears watchdog and prescaler, sets timeout, clears powerdown
// RULE10 - after sleep the core sits in sleep with the oscillator halted
// RULE11 - zero flag set when the 8-bit result is zero, else cleared
module subtract_xor_swap_execute #(
  parameter int DATA_W = exec_pkg::DATA_W,
  parameter int ADDR_W = exec_pkg::ADDR_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic exec_valid,
  input wire exec_pkg::op_e exec_op,
  input wire logic [DATA_W-1:0] literal,
  input wire logic [ADDR_W-1:0] file_addr,
  input wire logic dest_bit,
  input wire logic [DATA_W-1:0] file_rdata,
  input wire logic sleep_req,
  input wire logic wake_req,
  input wire logic watchdog_tick,
  input wire logic prescale_tick,
  output logic [DATA_W-1:0] working_ff,
  output logic file_we_ff,
  output logic [ADDR_W-1:0] file_waddr_ff,
  output logic [DATA_W-1:0] file_wdata_ff,
  output logic carry_flag_ff,
  output logic digit_carry_flag_ff,
  output logic zero_flag_ff,
  output logic [DATA_W-1:0] port_a_direction_ff,
  output logic [DATA_W-1:0] port_b_direction_ff,
  output logic [DATA_W-1:0] port_c_direction_ff,
  output logic timeout_status_bit_ff,
  output logic powerdown_status_bit_ff,
  output logic [exec_pkg::WATCHDOG_W-1:0] watchdog_counter_ff,
  output logic [exec_pkg::PRE_W-1:0] prescaler_ff,
  output logic sleeping_ff,
  output logic osc_run_ff
);
  logic [DATA_W-1:0] sub_a;
  logic [DATA_W-1:0] sub_diff;
  logic sub_cin;
  logic sub_c;
  logic sub_digit;
  logic [DATA_W-1:0] nxt_result;
  logic to_w;
  logic to_f;
  logic upd_c;
  logic upd_z;
  logic go;

  // instructions are not executed while asleep
  assign go = exec_valid && !sleeping_ff;

  always_comb begin
    sub_a = file_rdata;
    sub_cin = 1'b1;
    unique case (exec_op)
      exec_pkg::OP_SUBTRACT_FROM_LITERAL: sub_a = literal; // RULE1
      exec_pkg::OP_SUBTRACT_REGISTER_WITH_BORROW: sub_cin = carry_flag_ff; // RULE3
      default: sub_a = file_rdata; // RULE2
    endcase
  end

  sub_unit #(.W(DATA_W)) u_sub (
    .minuend(sub_a),
    .subtrahend(working_ff),
    .carry_in(sub_cin),
    .diff(sub_diff),
    .carry_out(sub_c),
    .digit_carry_out(sub_digit)
  );

  always_comb begin
    nxt_result = sub_diff;
    to_w = 1'b0;
    to_f = 1'b0;
    upd_c = 1'b0;
    upd_z = 1'b0;
    unique case (exec_op)
      exec_pkg::OP_SUBTRACT_FROM_LITERAL: begin
        to_w = 1'b1; // RULE1
        upd_c = 1'b1;
        upd_z = 1'b1;
      end
      exec_pkg::OP_SUBTRACT_FROM_REGISTER,
      exec_pkg::OP_SUBTRACT_REGISTER_WITH_BORROW: begin
        to_w = !dest_bit; // RULE4
        to_f = dest_bit;
        upd_c = 1'b1; // RULE2 RULE3
        upd_z = 1'b1;
      end
      exec_pkg::OP_NIBBLE_SWAP: begin
        nxt_result = {file_rdata[3:0], file_rdata[7:4]}; // RULE5
        to_w = !dest_bit;
        to_f = dest_bit;
      end
      exec_pkg::OP_XOR_LITERAL: begin
        nxt_result = working_ff ^ literal; // RULE6
        to_w = 1'b1;
        upd_z = 1'b1;
      end
      exec_pkg::OP_XOR_REGISTER: begin
        nxt_result = working_ff ^ file_rdata; // RULE7
        to_w = !dest_bit;
        to_f = dest_bit;
        upd_z = 1'b1;
      end
      default: begin
        nxt_result = sub_diff;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      working_ff <= exec_pkg::W_RST;
    end else if (go && to_w) begin
      working_ff <= nxt_result; // RULE4
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      file_we_ff <= 1'b0;
      file_waddr_ff <= '0;
      file_wdata_ff <= '0;
    end else begin
      file_we_ff <= go && to_f; // RULE4
      if (go && to_f) begin
        file_waddr_ff <= file_addr;
        file_wdata_ff <= nxt_result;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      carry_flag_ff <= 1'b0;
      digit_carry_flag_ff <= 1'b0;
      zero_flag_ff <= 1'b0;
    end else if (go) begin
      if (upd_c) begin
        carry_flag_ff <= sub_c; // RULE1 RULE2 RULE3
        digit_carry_flag_ff <= sub_digit;
      end
      if (upd_z) begin
        zero_flag_ff <= (nxt_result == '0); // RULE11
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      port_a_direction_ff <= exec_pkg::DIR_RST;
      port_b_direction_ff <= exec_pkg::DIR_RST;
      port_c_direction_ff <= exec_pkg::DIR_RST;
    end else if (go && exec_op == exec_pkg::OP_LOAD_DIRECTION) begin
      // other operand values are ignored
      if (file_addr[2:0] == exec_pkg::DIR_SEL_A && file_addr[ADDR_W-1:3] == '0) begin
        port_a_direction_ff <= working_ff; // RULE8
      end
      if (file_addr[2:0] == exec_pkg::DIR_SEL_B && file_addr[ADDR_W-1:3] == '0) begin
        port_b_direction_ff <= working_ff; // RULE8
      end
      if (file_addr[2:0] == exec_pkg::DIR_SEL_C && file_addr[ADDR_W-1:3] == '0) begin
        port_c_direction_ff <= working_ff; // RULE8
      end
    end
  end

  // watchdog keeps counting in sleep; its own tick source is outside this block
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      watchdog_counter_ff <= exec_pkg::WATCHDOG_CLR;
      prescaler_ff <= '0;
    end else if (sleep_req && !sleeping_ff) begin
      watchdog_counter_ff <= exec_pkg::WATCHDOG_CLR; // RULE9
      prescaler_ff <= '0;
    end else begin
      if (prescale_tick) begin
        prescaler_ff <= prescaler_ff + 1'b1;
      end
      if (watchdog_tick) begin
        watchdog_counter_ff <= watchdog_counter_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      timeout_status_bit_ff <= 1'b1;
      powerdown_status_bit_ff <= 1'b1;
    end else if (sleep_req && !sleeping_ff) begin
      timeout_status_bit_ff <= 1'b1; // RULE9
      powerdown_status_bit_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sleeping_ff <= 1'b0;
      osc_run_ff <= 1'b1;
    end else if (sleep_req && !sleeping_ff) begin
      sleeping_ff <= 1'b1; // RULE10
      osc_run_ff <= 1'b0;
    end else if (wake_req) begin
      sleeping_ff <= 1'b0;
      osc_run_ff <= 1'b1;
    end
  end

  sleep_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE9
    sleep_req && !sleeping_ff |=> watchdog_counter_ff == exec_pkg::WATCHDOG_CLR
      && prescaler_ff == '0 && timeout_status_bit_ff && !powerdown_status_bit_ff)
    else $error("sleep did not clear watchdog or set status");

  sleep_state_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE10
    sleep_req && !sleeping_ff && !wake_req |=> sleeping_ff && !osc_run_ff)
    else $error("sleep state not entered");

  swap_flags_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE5
    go && exec_op == exec_pkg::OP_NIBBLE_SWAP |=> $stable(carry_flag_ff)
      && $stable(zero_flag_ff) && $stable(digit_carry_flag_ff))
    else $error("nibble swap changed a flag");

  swap_data_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE5
    go && exec_op == exec_pkg::OP_NIBBLE_SWAP && !dest_bit
      |=> working_ff == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
    else $error("nibble swap result wrong");

  sublit_carry_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE1
    go && exec_op == exec_pkg::OP_SUBTRACT_FROM_LITERAL
      |=> carry_flag_ff == ($past(working_ff) <= $past(literal))
        && working_ff == 8'($past(literal) - $past(working_ff)))
    else $error("subtract from literal wrong");

  subreg_dest_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE4
    go && exec_op == exec_pkg::OP_SUBTRACT_FROM_REGISTER && dest_bit
      |=> file_we_ff && $stable(working_ff)
        && file_wdata_ff == 8'($past(file_rdata) - $past(working_ff)))
    else $error("subtract register destination wrong");

  xorlit_flags_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE6
    go && exec_op == exec_pkg::OP_XOR_LITERAL
      |=> $stable(carry_flag_ff) && zero_flag_ff == (working_ff == '0)
        && working_ff == ($past(working_ff) ^ $past(literal)))
    else $error("xor literal flags wrong");

  xorreg_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE7
    go && exec_op == exec_pkg::OP_XOR_REGISTER
      |=> zero_flag_ff == (($past(working_ff) ^ $past(file_rdata)) == '0)
        && $stable(digit_carry_flag_ff))
    else $error("xor register zero wrong");

  dir_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE8
    go && exec_op == exec_pkg::OP_LOAD_DIRECTION && file_addr == 7'h06
      |=> port_b_direction_ff == $past(working_ff) && !file_we_ff)
    else $error("direction load wrong");
endmodule

// ---- test/subtract_xor_swap_execute_tb_top.sv ----
// self-checking bench for the subtract/xor/swap execute block
`timescale 1ns/1ps
module subtract_xor_swap_execute_tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic exec_valid = 1'b0;
  exec_pkg::op_e exec_op = exec_pkg::OP_NONE;
  logic [7:0] literal = 8'h00;
  logic [6:0] file_addr = 7'h00;
  logic dest_bit = 1'b0;
  logic [7:0] file_rdata = 8'h00;
  logic sleep_req = 1'b0;
  logic wake_req = 1'b0;
  logic watchdog_tick = 1'b0;
  logic prescale_tick = 1'b0;
  logic [7:0] working_ff, file_wdata_ff, port_a_direction_ff, port_b_direction_ff;
  logic [7:0] port_c_direction_ff, watchdog_counter_ff, prescaler_ff;
  logic [6:0] file_waddr_ff;
  logic file_we_ff, carry_flag_ff, digit_carry_flag_ff, zero_flag_ff;
  logic timeout_status_bit_ff, powerdown_status_bit_ff, sleeping_ff, osc_run_ff;
  int n_fail = 0;
  int checked = 0;
  logic [15:0] seed = 16'h0019;
  logic [15:0] rnd;
  // reference state, reset values
  int w = 0, c = 0, dcy = 0, z = 0, we = 0, wa = 0, wd = 0;
  int da = 255, db = 255, dcd = 255, tob = 1, pdb = 1, wdt = 0, pre = 0, slp = 0;

  subtract_xor_swap_execute i_dut (.clk_sys, .rst_n, .exec_valid, .exec_op, .literal,
    .file_addr, .dest_bit, .file_rdata, .sleep_req, .wake_req, .watchdog_tick,
    .prescale_tick, .working_ff, .file_we_ff, .file_waddr_ff, .file_wdata_ff,
    .carry_flag_ff, .digit_carry_flag_ff, .zero_flag_ff, .port_a_direction_ff,
    .port_b_direction_ff, .port_c_direction_ff, .timeout_status_bit_ff,
    .powerdown_status_bit_ff, .watchdog_counter_ff, .prescaler_ff, .sleeping_ff,
    .osc_run_ff);

  always #25 clk_sys = ~clk_sys;

  function automatic logic [15:0] nxt_lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic close_out();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input int exp);
    checked++;
    if (got !== exp[15:0]) begin
      n_fail++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp[15:0]);
    end
  endtask

  task automatic check_all();
    chk(working_ff, w);
    chk({carry_flag_ff, digit_carry_flag_ff}, c * 2 + dcy);
    chk(zero_flag_ff, z);
    chk(file_we_ff, we);
    if (we) chk({file_waddr_ff, file_wdata_ff}, wa * 256 + wd);
    chk({port_a_direction_ff, port_b_direction_ff}, da * 256 + db);
    chk(port_c_direction_ff, dcd);
    chk({timeout_status_bit_ff, powerdown_status_bit_ff}, tob * 2 + pdb);
    chk({watchdog_counter_ff, prescaler_ff}, wdt * 256 + pre);
    chk(sleeping_ff, slp);
    chk(osc_run_ff, 1 - slp);
  endtask

  // inputs change at the falling edge and hold until the next step
  task automatic step(input int v, op, k, f, d, rd, s, wk, t);
    int a, bin, r;
    exec_valid = v[0];
    exec_op = exec_pkg::op_e'(3'(op));
    literal = 8'(k);
    file_addr = 7'(f);
    dest_bit = d[0];
    file_rdata = 8'(rd);
    sleep_req = s[0];
    wake_req = wk[0];
    watchdog_tick = t[0];
    prescale_tick = t[1];
    @(posedge clk_sys);
    @(negedge clk_sys);
    a = (op == 1) ? k : rd;
    bin = (op == 3) ? 1 - c : 0;
    we = 0;
    // execution is judged on the sleep state before this edge
    if (!slp && v) begin
      r = a;
      case (op)
        1, 2, 3: begin
          r = a - w - bin;
          c = r >= 0;
          dcy = (a % 16) - (w % 16) - bin >= 0;
          r = r & 255;
          z = r == 0;
        end
        4: r = (a % 16) * 16 + a / 16;
        5: begin
          r = w ^ k;
          z = r == 0;
        end
        6: begin
          r = w ^ a;
          z = r == 0;
        end
        7: begin
          if (f == 5) da = w;
          if (f == 6) db = w;
          if (f == 7) dcd = w;
        end
        default: ;
      endcase
      if (op == 1 || op == 5 || (op inside {[2:4], 6} && !d)) w = r;
      else if (op inside {[2:4], 6}) begin
        we = 1;
        wa = f;
        wd = r;
      end
    end
    if (!slp && s) begin
      wdt = 0;
      pre = 0;
      tob = 1;
      pdb = 0;
      slp = 1;
    end else begin
      if (t[0]) wdt = (wdt + 1) % 256;
      if (t[1]) pre = (pre + 1) % 256;
      if (wk) slp = 0;
    end
    check_all();
  endtask

  initial begin
    repeat (2000) @(posedge clk_sys);
    n_fail++;
    close_out();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    check_all();
    chk(osc_run_ff, 1);
    step(1, 5, 'h3C, 0, 0, 0, 0, 0, 0);
    step(1, 1, 'h3C, 0, 0, 0, 0, 0, 0);
    step(1, 5, 'h01, 0, 0, 0, 0, 0, 0);
    step(1, 1, 'h00, 0, 0, 0, 0, 0, 0);
    step(1, 3, 0, 'h7F, 1, 'h00, 0, 0, 0);
    step(1, 2, 0, 'h12, 0, 'h11, 0, 0, 0);
    step(1, 4, 0, 'h33, 1, 'hA5, 0, 0, 0);
    step(1, 6, 0, 'h40, 1, 'h5A, 0, 0, 0);
    for (int f = 4; f < 8; f++) step(1, 7, 0, f, 0, 0, 0, 0, 0);
    repeat (3) step(0, 0, 0, 0, 0, 0, 0, 0, 3);
    step(0, 0, 0, 0, 0, 0, 0, 0, 1);
    // tick on the sleep edge: the clear must win
    step(0, 0, 0, 0, 0, 0, 1, 0, 3);
    step(1, 5, 'hFF, 0, 0, 0, 0, 0, 0);
    step(0, 0, 0, 0, 0, 0, 1, 0, 0);
    step(0, 0, 0, 0, 0, 0, 0, 1, 0);
    for (int i = 0; i < 80; i++) begin
      seed = nxt_lfsr(seed);
      rnd = seed;
      seed = nxt_lfsr(seed);
      // idle cycles with a live op check that nothing runs without valid
      step(rnd[14] | seed[0], 1 + rnd % 7, rnd[7:0],
           (rnd % 7 == 6) ? 4 + seed[1:0] : seed[14:8], rnd[15], seed[7:0], 0, 0,
           seed[15:14]);
    end
    step(0, 0, 0, 0, 0, 0, 0, 0, 0);
    close_out();
  end
endmodule
